// ### design/fpt_fan_throttle.sv
`timescale 1ns/10ps
module fpt_fan_throttle #(
  parameter int unsigned MS_CYCLES = fpt_pkg::MS_CYC,
  parameter fpt_pkg::fpt_rate_arr_t RATE_STEP_CYC = fpt_pkg::rate_steps()
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] zone1_duty_code,
  input wire logic [3:0] zone2_duty_code,
  input wire logic [3:0] zone3_duty_code,
  input wire logic [3:0] zone4_duty_code,
  input wire logic cpu1_throttle_pin_n,
  input wire logic cpu2_throttle_pin_n,
  input wire logic vreg1_hot_pin_n,
  input wire logic vreg2_hot_pin_n,
  output logic cpu1_throttle_pin_n_out,
  output logic cpu1_throttle_pin_oe_n,
  output logic cpu2_throttle_pin_n_out,
  output logic cpu2_throttle_pin_oe_n,
  output logic fan_drive_1,
  output logic fan_drive_2,
  output logic [3:0] cpu1_watch_interval,
  output logic [3:0] cpu2_watch_interval
);
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [7:0] ramp_reg;
  logic [7:0] interval_reg;
  logic force1_reg;
  logic force2_reg;
  logic [3:0] thr_duty_reg;
  logic lock_reg;
  logic tied_reg;
  logic [15:0] ms_cnt_reg;
  logic [10:0] tick_cnt_reg;
  logic [6:0] thr_cnt_reg;
  logic thr1_n_reg;
  logic thr2_n_reg;
  logic [3:0] ramp_code [4];
  logic [3:0] zone_code [4];
  logic [7:0] rd_bind [2];
  logic [7:0] rd_ovr [2];
  logic [7:0] rd_spin [2];
  logic [7:0] rd_rate [2];
  logic drive_w [2];

  // ==========================================================
  // apb slave: one wait state, so every output is a flop
  wire [7:0] idx = paddr[9:2];
  wire setup_acc = psel & penable & ~pready_reg;
  wire wr_en = psel & penable & pready_reg & pwrite;
  // the global lock freezes fan setup, not the lock flags
  wire wr_lk = wr_en & ~lock_reg;
  wire force_wr = wr_en & (idx == fpt_pkg::IDX_FORCE);
  wire intv_wr = wr_en & (idx == fpt_pkg::IDX_INTERVAL);
  wire ramp_wr = wr_lk & (idx == fpt_pkg::IDX_RAMP);
  wire cfg_wr = wr_lk & (idx == fpt_pkg::IDX_CONFIG);

  wire [7:0] rd_force = {force2_reg, force1_reg, 2'h0, thr_duty_reg};
  wire [7:0] rd_cfg = {3'h0, tied_reg, 2'h0, lock_reg, 1'b0};
  wire [7:0] rd8 =
    ({8{idx == fpt_pkg::IDX_RAMP}} & ramp_reg) |
    ({8{idx == fpt_pkg::IDX_FORCE}} & rd_force) |
    ({8{idx == fpt_pkg::IDX_INTERVAL}} & interval_reg) |
    ({8{idx == fpt_pkg::IDX_BIND[0]}} & rd_bind[0]) |
    ({8{idx == fpt_pkg::IDX_OVR[0]}} & rd_ovr[0]) |
    ({8{idx == fpt_pkg::IDX_SPIN[0]}} & rd_spin[0]) |
    ({8{idx == fpt_pkg::IDX_RATE[0]}} & rd_rate[0]) |
    ({8{idx == fpt_pkg::IDX_BIND[1]}} & rd_bind[1]) |
    ({8{idx == fpt_pkg::IDX_OVR[1]}} & rd_ovr[1]) |
    ({8{idx == fpt_pkg::IDX_SPIN[1]}} & rd_spin[1]) |
    ({8{idx == fpt_pkg::IDX_RATE[1]}} & rd_rate[1]) |
    ({8{idx == fpt_pkg::IDX_CONFIG}} & rd_cfg);
  wire hit = (idx == fpt_pkg::IDX_RAMP) | (idx == fpt_pkg::IDX_FORCE) |
             (idx == fpt_pkg::IDX_INTERVAL) | (idx == fpt_pkg::IDX_CONFIG) |
             (idx[7:3] == fpt_pkg::IDX_BIND[0][7:3]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= setup_acc;
      pslverr_reg <= setup_acc & ~hit;
      if (setup_acc) begin
        prdata_reg <= (pwrite | ~hit) ? 32'h0000_0000 : {24'h00_0000, rd8};
      end
    end
  end

  // ==========================================================
  // global registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_reg <= fpt_pkg::RST_ZERO;
      interval_reg <= fpt_pkg::RST_INTERVAL;
      force1_reg <= 1'b0;
      force2_reg <= 1'b0;
      thr_duty_reg <= fpt_pkg::CODE_ZERO;
      lock_reg <= 1'b0;
      tied_reg <= 1'b0;
    end else begin
      if (ramp_wr) begin
        ramp_reg <= pwdata[7:0];
      end
      // interval codes kept as written, reserved ones too
      if (intv_wr) begin
        interval_reg <= pwdata[7:0];
      end
      if (force_wr) begin
        force1_reg <= pwdata[fpt_pkg::FORCE1_BIT];
        force2_reg <= pwdata[fpt_pkg::FORCE2_BIT];
        thr_duty_reg <= pwdata[fpt_pkg::THR_DUTY_LSB +: 4];
      end
      // lock only sets; reset alone clears it
      if (cfg_wr) begin
        lock_reg <= pwdata[fpt_pkg::CFG_LOCK_BIT];
        tied_reg <= pwdata[fpt_pkg::CFG_TIED_BIT];
      end
    end
  end

  // ==========================================================
  // time bases: 1 ms for ramps and spin-up, 22.5 kHz for throttle
  wire ms_tick = ms_cnt_reg == 16'(MS_CYCLES - 1);
  wire tick = tick_cnt_reg == 11'(fpt_pkg::TICK_CYC - 1);
  wire thr_last = thr_cnt_reg == fpt_pkg::THR_PERIOD - 7'h01;
  // five ticks per code step, plus one step
  wire thr_on = thr_cnt_reg < fpt_pkg::THR_STEP * 7'({3'h0, thr_duty_reg} + 7'h01);
  // tied pins follow either force bit
  wire drv1 = thr_on & (force1_reg | (tied_reg & force2_reg));
  wire drv2 = thr_on & (force2_reg | (tied_reg & force1_reg));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_reg <= 16'h0000;
      tick_cnt_reg <= 11'h000;
      thr_cnt_reg <= 7'h00;
      thr1_n_reg <= 1'b1;
      thr2_n_reg <= 1'b1;
    end else begin
      ms_cnt_reg <= ms_tick ? 16'h0000 : ms_cnt_reg + 16'h0001;
      tick_cnt_reg <= tick ? 11'h000 : tick_cnt_reg + 11'h001;
      if (tick) begin
        thr_cnt_reg <= thr_last ? 7'h00 : thr_cnt_reg + 7'h01;
      end
      thr1_n_reg <= ~drv1;
      thr2_n_reg <= ~drv2;
    end
  end

  // ==========================================================
  // ramp sources: cpu1, cpu2, vreg1, vreg2 (pins active low)
  wire [3:0] hot = ~{vreg2_hot_pin_n, vreg1_hot_pin_n, cpu2_throttle_pin_n,
                     cpu1_throttle_pin_n};
  genvar s;
  for (s = 0; s < 4; s++) begin : g_ramp
    logic [3:0] code_reg;
    logic [9:0] ms_reg;
    wire [3:0] dly = (s < 2) ? ramp_reg[fpt_pkg::PH_RAMP_LSB +: 4]
                             : ramp_reg[fpt_pkg::VR_RAMP_LSB +: 4];
    wire [9:0] step_ms = {6'h00, dly} * fpt_pkg::RAMP_STEP_MS;
    wire at_end = hot[s] ? (code_reg == fpt_pkg::CODE_FULL)
                         : (code_reg == fpt_pkg::CODE_ZERO);
    wire step = ms_tick & ~at_end & (ms_reg >= step_ms - 10'h001);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        code_reg <= fpt_pkg::CODE_ZERO;
        ms_reg <= 10'h000;
      end else if (dly == fpt_pkg::CODE_ZERO) begin
        code_reg <= hot[s] ? fpt_pkg::CODE_FULL : fpt_pkg::CODE_ZERO;
        ms_reg <= 10'h000;
      end else if (step) begin
        ms_reg <= 10'h000;
        code_reg <= hot[s] ? code_reg + 4'h1 : code_reg - 4'h1;
      end else if (ms_tick & ~at_end) begin
        ms_reg <= ms_reg + 10'h001;
      end
    end
    assign ramp_code[s] = code_reg;
  end

  assign zone_code[0] = zone1_duty_code;
  assign zone_code[1] = zone2_duty_code;
  assign zone_code[2] = zone3_duty_code;
  assign zone_code[3] = zone4_duty_code;

  // ==========================================================
  // fan channels
  genvar f;
  for (f = 0; f < 2; f++) begin : g_fan
    logic [7:0] bind_reg;
    logic ovr_en_reg;
    logic inv_reg;
    logic lock_en_reg;
    logic lock_flag_reg;
    logic [3:0] man_duty_reg;
    logic [3:0] spin_duty_reg;
    logic [2:0] spin_time_reg;
    logic [2:0] rate_reg;
    logic [3:0] req_code;
    logic [3:0] duty_code;
    wire bind_wr = wr_lk & (idx == fpt_pkg::IDX_BIND[f]);
    wire ovr_hit = wr_en & (idx == fpt_pkg::IDX_OVR[f]);
    wire spin_wr = wr_lk & (idx == fpt_pkg::IDX_SPIN[f]);
    wire rate_wr = wr_lk & (idx == fpt_pkg::IDX_RATE[f]);
    wire thr_evt = |(bind_reg[fpt_pkg::SRC_THR_LSB +: 2] & hot[1:0]);
    // event wins over a clear; clear ignores the lock
    wire lock_flag_next = (lock_en_reg & thr_evt) |
      (lock_flag_reg & ~(ovr_hit & ~pwdata[fpt_pkg::LOCK_FLAG_BIT]));

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        bind_reg <= fpt_pkg::RST_BIND;
        ovr_en_reg <= 1'b0;
        inv_reg <= 1'b0;
        lock_en_reg <= 1'b0;
        lock_flag_reg <= 1'b0;
        man_duty_reg <= fpt_pkg::CODE_ZERO;
        spin_duty_reg <= fpt_pkg::CODE_ZERO;
        spin_time_reg <= fpt_pkg::SPIN_OFF;
        rate_reg <= 3'h0;
      end else begin
        if (bind_wr) begin
          bind_reg <= pwdata[7:0];
        end
        if (ovr_hit & ~lock_reg) begin
          ovr_en_reg <= pwdata[fpt_pkg::OVR_EN_BIT];
          inv_reg <= pwdata[fpt_pkg::INV_BIT];
          lock_en_reg <= pwdata[fpt_pkg::LOCK_EN_BIT];
          man_duty_reg <= pwdata[fpt_pkg::MAN_DUTY_LSB +: 4];
        end
        lock_flag_reg <= lock_flag_next;
        if (spin_wr) begin
          spin_duty_reg <= pwdata[fpt_pkg::SPIN_DUTY_LSB +: 4];
          spin_time_reg <= pwdata[fpt_pkg::SPIN_TIME_LSB +: 3];
        end
        if (rate_wr) begin
          rate_reg <= pwdata[fpt_pkg::RATE_LSB +: 3];
        end
      end
    end

    always_comb begin
      logic [3:0] m;
      m = fpt_pkg::CODE_ZERO;
      for (int z = 0; z < 4; z++) begin
        if (bind_reg[z] && zone_code[z] > m) begin
          m = zone_code[z];
        end
        if (bind_reg[fpt_pkg::SRC_THR_LSB + z] && ramp_code[z] > m) begin
          m = ramp_code[z];
        end
      end
      if (ovr_en_reg && man_duty_reg > m) begin
        m = man_duty_reg;
      end
      // held at full while the flag stands
      if (lock_flag_reg) begin
        m = fpt_pkg::CODE_FULL;
      end
      req_code = m;
    end

    fpt_fan_channel #(
      .RATE_STEP_CYC(RATE_STEP_CYC)
    ) u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .ms_tick(ms_tick),
      .req_code(req_code),
      .spin_time(spin_time_reg),
      .spin_duty(spin_duty_reg),
      .rate_sel(rate_reg),
      .invert(inv_reg),
      .drive(drive_w[f]),
      .duty_code(duty_code)
    );

    assign rd_bind[f] = bind_reg;
    // manual duty field reads the driven code
    assign rd_ovr[f] = {duty_code, lock_flag_reg, lock_en_reg, inv_reg, ovr_en_reg};
    assign rd_spin[f] = {spin_time_reg, 1'b0, spin_duty_reg};
    assign rd_rate[f] = {5'h00, rate_reg};
  end

  // ==========================================================
  // outputs
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign fan_drive_1 = drive_w[0];
  assign fan_drive_2 = drive_w[1];
  // open drain: pulled low only while asserting
  assign cpu1_throttle_pin_n_out = thr1_n_reg;
  assign cpu1_throttle_pin_oe_n = thr1_n_reg;
  assign cpu2_throttle_pin_n_out = thr2_n_reg;
  assign cpu2_throttle_pin_oe_n = thr2_n_reg;
  assign cpu1_watch_interval = interval_reg[3:0];
  assign cpu2_watch_interval = interval_reg[7:4];

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_zone_max: assert property (
    g_fan[0].bind_reg[0] |-> g_fan[0].req_code >= zone1_duty_code)
    else $error("bound zone exceeds fan request");
  a_manual_floor: assert property (
    g_fan[1].ovr_en_reg |-> g_fan[1].req_code >= g_fan[1].man_duty_reg)
    else $error("manual duty not honoured");
  a_lock_full: assert property (
    (g_fan[0].lock_en_reg && g_fan[0].thr_evt) |=>
      g_fan[0].lock_flag_reg && g_fan[0].req_code == fpt_pkg::CODE_FULL)
    else $error("throttle lock did not hold full duty");
  a_lock_idle: assert property (
    (!g_fan[0].lock_en_reg && !g_fan[0].lock_flag_reg) |=> !g_fan[0].lock_flag_reg)
    else $error("lock flag set while disabled");
  a_flag_clear: assert property (
    (lock_reg && g_fan[0].ovr_hit && !pwdata[fpt_pkg::LOCK_FLAG_BIT] &&
     !(g_fan[0].lock_en_reg && g_fan[0].thr_evt)) |=> !g_fan[0].lock_flag_reg)
    else $error("lock flag clear blocked by register lock");
  a_duty_read: assert property (
    (setup_acc && !pwrite && idx == fpt_pkg::IDX_OVR[0]) |=>
      prdata[7:4] == $past(g_fan[0].duty_code))
    else $error("manual duty read not the driven code");
  a_tied_pins: assert property (
    (tied_reg && (force1_reg || force2_reg)) |=>
      cpu1_throttle_pin_oe_n == cpu2_throttle_pin_oe_n)
    else $error("tied throttle pins differ");
  a_thr_min: assert property (
    (force1_reg && thr_cnt_reg < fpt_pkg::THR_STEP) |=> !cpu1_throttle_pin_oe_n)
    else $error("throttle pulse shorter than five ticks");
  a_thr_period: assert property (
    (tick && thr_last) |=> thr_cnt_reg == 7'h00)
    else $error("throttle period not 80 ticks");
  a_ramp_jump: assert property (
    (hot[0] && ramp_reg[fpt_pkg::PH_RAMP_LSB +: 4] == fpt_pkg::CODE_ZERO) |=>
      ramp_code[0] == fpt_pkg::CODE_FULL)
    else $error("zero ramp delay did not jump to full");
  a_apb_wait: assert property (
    setup_acc |=> pready_reg ##1 !pready_reg)
    else $error("apb answer not one wait state");

  c_write: cover property (wr_en && idx == fpt_pkg::IDX_BIND[0]);
  c_lock_set: cover property ($rose(g_fan[0].lock_flag_reg));
  c_force: cover property (force1_reg && tied_reg ##1 !cpu2_throttle_pin_oe_n);
  c_ramp_up: cover property (ramp_code[2] == 4'h3);
endmodule // fpt_fan_throttle

// ### shared/fpt_pkg.sv
// ==========================================================
// clock and tick rates
package fpt_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_HZ = 22_500;
  localparam int unsigned TICK_CYC = CLK_HZ / TICK_HZ;
  localparam int unsigned MS_CYC = CLK_HZ / 1_000;
  localparam int unsigned PWM_STEPS = 256;

  // ==========================================================
  // fan output rates and step lengths
  typedef int unsigned fpt_rate_arr_t [8];
  localparam fpt_rate_arr_t RATE_HZ = '{22_500, 96, 84, 72, 60, 48, 36, 12};
  function automatic fpt_rate_arr_t rate_steps();
    fpt_rate_arr_t r;
    for (int i = 0; i < 8; i++) begin
      r[i] = CLK_HZ / (RATE_HZ[i] * PWM_STEPS);
    end
    return r;
  endfunction

  // ==========================================================
  // spin-up, ramp, duty table, throttle train
  typedef logic [11:0] fpt_ms_arr_t [8];
  localparam fpt_ms_arr_t SPIN_MS = '{12'h000, 12'h064, 12'h0fa, 12'h190,
                                      12'h2bc, 12'h3e8, 12'h7d0, 12'hfa0};
  localparam logic [2:0] SPIN_OFF = 3'h0;
  localparam logic [9:0] RAMP_STEP_MS = 10'h032;
  typedef logic [7:0] fpt_duty_tab_t [16];
  localparam fpt_duty_tab_t DUTY_TAB = '{8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55,
                                         8'h66, 8'h77, 8'h88, 8'h99, 8'haa, 8'hbb,
                                         8'hcc, 8'hdd, 8'hee, 8'hff};
  localparam logic [3:0] CODE_ZERO = 4'h0;
  localparam logic [3:0] CODE_FULL = 4'hf;
  localparam logic [6:0] THR_PERIOD = 7'h50;
  localparam logic [6:0] THR_STEP = 7'h05;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_RAMP = 8'hbf;
  localparam logic [7:0] IDX_FORCE = 8'hc6;
  localparam logic [7:0] IDX_INTERVAL = 8'hc7;
  localparam logic [7:0] IDX_BIND [2] = '{8'hc8, 8'hcc};
  localparam logic [7:0] IDX_OVR [2] = '{8'hc9, 8'hcd};
  localparam logic [7:0] IDX_SPIN [2] = '{8'hca, 8'hce};
  localparam logic [7:0] IDX_RATE [2] = '{8'hcb, 8'hcf};
  localparam logic [7:0] IDX_CONFIG = 8'he3;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_INTERVAL = 8'h11;
  localparam logic [7:0] RST_BIND = 8'h0f;

  // ==========================================================
  // field positions
  localparam int THR_DUTY_LSB = 0;
  localparam int FORCE1_BIT = 6;
  localparam int FORCE2_BIT = 7;
  localparam int SRC_THR_LSB = 4;
  localparam int OVR_EN_BIT = 0;
  localparam int INV_BIT = 1;
  localparam int LOCK_EN_BIT = 2;
  localparam int LOCK_FLAG_BIT = 3;
  localparam int MAN_DUTY_LSB = 4;
  localparam int SPIN_DUTY_LSB = 0;
  localparam int SPIN_TIME_LSB = 5;
  localparam int RATE_LSB = 0;
  localparam int VR_RAMP_LSB = 0;
  localparam int PH_RAMP_LSB = 4;
  localparam int CFG_LOCK_BIT = 1;
  localparam int CFG_TIED_BIT = 4;
endpackage

// ### design/fpt_fan_channel.sv
`timescale 1ns/10ps
module fpt_fan_channel #(
  parameter fpt_pkg::fpt_rate_arr_t RATE_STEP_CYC = fpt_pkg::rate_steps()
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ms_tick,
  input wire logic [3:0] req_code,
  input wire logic [2:0] spin_time,
  input wire logic [3:0] spin_duty,
  input wire logic [2:0] rate_sel,
  input wire logic invert,
  output logic drive,
  output logic [3:0] duty_code
);
  logic spin_reg;
  logic spin_next;
  logic prev_zero_reg;
  logic [11:0] spin_ms_reg;
  logic [3:0] duty_reg;
  logic [15:0] pre_reg;
  logic [7:0] phase_reg;
  logic drive_reg;

  // ==========================================================
  // spin-up
  // start on zero to non-zero
  wire spin_start = prev_zero_reg & (req_code != fpt_pkg::CODE_ZERO) &
                    (spin_time != fpt_pkg::SPIN_OFF) & (spin_duty != fpt_pkg::CODE_ZERO);
  wire spin_done = spin_ms_reg >= fpt_pkg::SPIN_MS[spin_time];
  // a request falling back to zero aborts the sequence
  assign spin_next = spin_start |
                     (spin_reg & ~spin_done & (req_code != fpt_pkg::CODE_ZERO));

  // ==========================================================
  // pwm
  // step length per rate code
  wire [15:0] step_last = 16'(RATE_STEP_CYC[rate_sel] - 1);
  // >= so a rate change mid-step never wraps the prescaler
  wire step_wrap = pre_reg >= step_last;
  // full code is a steady level
  wire level = (duty_reg == fpt_pkg::CODE_FULL) | (phase_reg < fpt_pkg::DUTY_TAB[duty_reg]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_zero_reg <= 1'b1;
      spin_reg <= 1'b0;
      spin_ms_reg <= 12'h000;
      duty_reg <= fpt_pkg::CODE_ZERO;
      pre_reg <= 16'h0000;
      phase_reg <= 8'h00;
      drive_reg <= 1'b0;
    end else begin
      prev_zero_reg <= req_code == fpt_pkg::CODE_ZERO;
      spin_reg <= spin_next;
      if (spin_start) begin
        spin_ms_reg <= 12'h000;
      end else if (spin_reg & ms_tick) begin
        spin_ms_reg <= spin_ms_reg + 12'h001;
      end
      duty_reg <= spin_next ? spin_duty : req_code;
      pre_reg <= step_wrap ? 16'h0000 : pre_reg + 16'h0001;
      if (step_wrap) begin
        phase_reg <= phase_reg + 8'h01;
      end
      drive_reg <= level ^ invert;
    end
  end

  assign drive = drive_reg;
  assign duty_code = duty_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_full_level: assert property (
    (duty_reg == fpt_pkg::CODE_FULL) |=> (drive_reg != $past(invert)))
    else $error("full duty not a steady level");
  a_spin_duty: assert property (
    spin_start |=> spin_reg && duty_reg == $past(spin_duty))
    else $error("spin-up did not drive its duty");
  c_spin: cover property (spin_start ##1 spin_reg [*3]);
endmodule // fpt_fan_channel

// ### verification/fpt_cpu_model.sv
`timescale 1ns/10ps
// ====================
// processor side of the two open-drain throttle pins, pulled up
module fpt_cpu_model (
  input wire logic hot1,
  input wire logic hot2,
  input wire logic oe1_n,
  input wire logic oe2_n,
  output logic pin1_n,
  output logic pin2_n
);
  assign pin1_n = oe1_n & ~hot1;
  assign pin2_n = oe2_n & ~hot2;
endmodule // fpt_cpu_model

// ### verification/tb.sv
`timescale 1ns/10ps
module tb;
  localparam logic [7:0] rst_val [9] = '{8'h00, 8'h11, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h0f,
                                         8'h00, 8'h00};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, sl, ov, hot1 = 1'b0, vr1 = 1'b1;
  logic [3:0] zc [4] = '{default: 4'h0};
  logic p1_n, p2_n, o1, o2, oe1_n, oe2_n, fd1, fd2;
  logic [3:0] wi1, wi2;
  logic [7:0] rv, bnd, mv;
  int err_total = 0, comparisons = 0, n, e, cyc = 0, r0;
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  // ====================
  // design and far side
  fpt_fan_throttle #(.MS_CYCLES(40), .RATE_STEP_CYC('{default: 2})) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .zone1_duty_code(zc[0]), .zone2_duty_code(zc[1]), .zone3_duty_code(zc[2]),
    .zone4_duty_code(zc[3]), .cpu1_throttle_pin_n(p1_n), .cpu2_throttle_pin_n(p2_n),
    .vreg1_hot_pin_n(vr1), .vreg2_hot_pin_n(1'b1), .cpu1_throttle_pin_n_out(o1),
    .cpu1_throttle_pin_oe_n(oe1_n), .cpu2_throttle_pin_n_out(o2),
    .cpu2_throttle_pin_oe_n(oe2_n), .fan_drive_1(fd1), .fan_drive_2(fd2),
    .cpu1_watch_interval(wi1), .cpu2_watch_interval(wi2));
  fpt_cpu_model cpu (.hot1(hot1), .hot2(1'b0), .oe1_n(oe1_n), .oe2_n(oe2_n),
    .pin1_n(p1_n), .pin2_n(p2_n));
  // ====================
  // helpers
  task automatic give_verdict();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= 32'(wd);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rv = prdata[7:0];
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) err_total++;
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] ex, input string nm);
    apb(1'b0, idx, 8'h00);
    chk(nm, 32'(ex), 32'(rv));
  endtask
  function automatic logic [3:0] max_req(input logic [3:0] b, input logic o, input logic [3:0] m);
    logic [3:0] r;
    r = o ? m : 4'h0;
    for (int i = 0; i < 4; i++) if (b[i] && zc[i] > r) r = zc[i];
    return r;
  endfunction
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    give_verdict();
  end
  // ====================
  // tests
  initial begin
    void'($urandom(32'hae71));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    r0 = cyc;
    for (int i = 0; i < 9; i++) rdc(8'hc6 + 8'(i), rst_val[i], "reset");
    chk("interval", 32'h0000_0011, 32'({wi2, wi1}));
    mv = 8'($urandom);
    apb(1'b1, fpt_pkg::IDX_INTERVAL, mv); // set before any measurement runs
    @(posedge pclk);
    chk("interval", 32'(mv), 32'({wi2, wi1}));
    apb(1'b0, 8'h00, 8'h00);
    chk("slverr", 32'h0000_0001, 32'(sl));
    e = $urandom_range(1, 0);
    apb(1'b1, fpt_pkg::IDX_CONFIG, 8'h10);
    apb(1'b1, fpt_pkg::IDX_FORCE, 8'h40 | 8'(e));
    n = 0;
    while (oe1_n !== 1'b0 && n < 150000) begin
      @(posedge pclk);
      n++;
    end
    @(posedge pclk);
    chk("pin", 32'h0000_0000, 32'(p1_n));
    chk("tied", 32'h0000_0000, 32'(oe2_n));
    chk("pin_out", 32'h0000_0000, 32'({o2, o1}));
    n = 1;
    while (oe1_n === 1'b0 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    // the train starts the edge after reset release; the pin trails the counter a cycle
    chk("pulse", 32'(5 * (e + 1) * fpt_pkg::TICK_CYC + 2), 32'(cyc - r0));
    apb(1'b1, fpt_pkg::IDX_FORCE, 8'h00);
    apb(1'b1, fpt_pkg::IDX_CONFIG, 8'h00);
    apb(1'b1, fpt_pkg::IDX_SPIN[0], 8'h23);
    apb(1'b1, fpt_pkg::IDX_OVR[0], 8'h51);
    rdc(fpt_pkg::IDX_OVR[0], 8'h31, "spin");
    repeat (3800) @(posedge pclk);
    rdc(fpt_pkg::IDX_OVR[0], 8'h31, "spin");
    repeat (300) @(posedge pclk);
    rdc(fpt_pkg::IDX_OVR[0], 8'h51, "spin");
    for (int v = 0; v < 2; v++) begin
      apb(1'b1, fpt_pkg::IDX_OVR[0], 8'hf1 | 8'(v << 1));
      repeat (4) @(posedge pclk);
      repeat (16) begin
        @(posedge pclk);
        chk("drive", 32'(v == 0), 32'(fd1));
      end
    end
    apb(1'b1, fpt_pkg::IDX_SPIN[0], 8'h00);
    repeat (8) begin
      bnd = 8'($urandom);
      mv = 8'($urandom);
      ov = mv[0];
      foreach (zc[i]) zc[i] <= 4'($urandom);
      apb(1'b1, fpt_pkg::IDX_BIND[0], {4'h0, bnd[3:0]});
      apb(1'b1, fpt_pkg::IDX_OVR[0], {mv[7:4], 3'b000, ov});
      repeat (4) @(posedge pclk);
      rdc(fpt_pkg::IDX_OVR[0], {max_req(bnd[3:0], ov, mv[7:4]), 3'b000, ov}, "max");
    end
    foreach (zc[i]) zc[i] <= 4'h0;
    apb(1'b1, fpt_pkg::IDX_RAMP, 8'h01);
    apb(1'b1, fpt_pkg::IDX_BIND[0], 8'h40);
    apb(1'b1, fpt_pkg::IDX_OVR[0], 8'h00);
    vr1 <= 1'b0;
    // one code per 50 ms step: code 3 stands from about 6000 to 7960 cycles
    repeat (7000) @(posedge pclk);
    rdc(fpt_pkg::IDX_OVR[0], 8'h30, "ramp");
    apb(1'b1, fpt_pkg::IDX_BIND[1], 8'h10);
    apb(1'b1, fpt_pkg::IDX_OVR[1], 8'h04);
    apb(1'b1, fpt_pkg::IDX_CONFIG, 8'h02);
    hot1 <= 1'b1;
    repeat (4) @(posedge pclk);
    hot1 <= 1'b0;
    repeat (4) @(posedge pclk);
    rdc(fpt_pkg::IDX_OVR[1], 8'hfc, "lock");
    chk("drive2", 32'h0000_0001, 32'(fd2));
    apb(1'b1, fpt_pkg::IDX_OVR[1], 8'h00);
    rdc(fpt_pkg::IDX_OVR[1], 8'h04, "unlock");
    give_verdict();
  end
endmodule // tb
